// File: verilog/laser_cmd_pkg.sv
// constants and types for the serial laser command interpreter
package laser_cmd_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int BAUD = 9600;
  localparam int TMO_MS = 1000;
  localparam int GAP_MS = 1;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int TMO_CYC = (CLK_HZ / 1000) * TMO_MS;
  localparam int GAP_CYC = (CLK_HZ / 1000) * GAP_MS;
  localparam int REP_LEN = 6;
  localparam logic [3:0] LAST_BIT = 4'h9;
  // ------------------------------------------------------------
  // link bytes and command codes
  // ------------------------------------------------------------
  localparam logic [7:0] B_SOF = 8'h5B;
  localparam logic [7:0] B_ACK = 8'hAA;
  localparam logic [7:0] B_NAK = 8'h3F;
  localparam logic [7:0] B_STAT = 8'h7E;
  localparam logic [7:0] C_DUTY = 8'h7F;
  localparam logic [7:0] C_F5 = 8'h77;
  localparam logic [7:0] C_F10 = 8'h78;
  localparam logic [7:0] C_F20 = 8'h79;
  localparam logic [7:0] C_PU = 8'h7A;
  localparam logic [7:0] C_PD = 8'h7B;
  localparam logic [7:0] C_C95 = 8'h7C;
  localparam logic [7:0] C_C99 = 8'h7D;
  localparam logic [7:0] C_PWR_ON = 8'h30;
  localparam logic [7:0] C_PWR_OFF = 8'h31;
  localparam logic [7:0] C_MAN = 8'h70;
  localparam logic [7:0] C_LASE = 8'h75;
  localparam logic [7:0] C_STBY = 8'h76;
  localparam logic [7:0] DUTY_MAX = 8'hC6;
  localparam logic [2:0] M_MANUAL = 3'h0;
  localparam logic [2:0] M_CL_ANALOG = 3'h4;
  localparam logic [2:0] M_REMOTE = 3'h5;
  localparam logic [1:0] F_5K = 2'h0;
  localparam logic [1:0] F_10K = 2'h1;
  localparam logic [1:0] F_20K = 2'h2;
  localparam logic [3:0] FW_VER = 4'h1; // arbitrary value
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] mode;
    logic laser_on;
    logic gate_pull_up;
    logic [1:0] freq;
    logic lase_at_power_up;
    logic ceiling_95;
    logic [7:0] duty;
  } cfg_s;
  // status byte one, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] freq;
    logic gate_pull_up;
    logic laser_on;
    logic remote;
    logic [2:0] mode;
  } stat_one_s;
  // status byte two, bit 7 down to bit 0
  typedef struct packed {
    logic [3:0] fw;
    logic [1:0] rsvd;
    logic ceiling_95;
    logic lase_at_power_up;
  } stat_two_s;
  localparam cfg_s CFG_RST = '{mode: M_MANUAL, laser_on: 1'b0,
    gate_pull_up: 1'b1, freq: F_5K, lase_at_power_up: 1'b0,
    ceiling_95: 1'b1, duty: 8'h00};
endpackage

// File: verilog/laser_serial_command_parser.sv
// serial command interpreter: uart, frame parser, reply sequencer
// How it works
// RULE1: link is 9600 baud, 8 data bits, no parity, one stop bit, no flow.
// RULE2: ordinary frames are start byte, command byte, checksum byte.
// RULE3: start-of-frame byte is 5Bh; only it opens a frame.
// RULE4: three-byte checksum is the inverted command byte.
// RULE5: duty frame is start, 7Fh, data byte, checksum.
// RULE6: duty checksum is inverted 8-bit sum of command and data.
// RULE7: duty data is percent times two, C6h at most.
// RULE8: valid executed frame is answered with AAh.
// RULE9: bad checksum or one second timeout is answered with 3Fh.
// RULE10: setup codes set frequency, gate pull, ceiling, power-up lasing.
// RULE11: mode codes 70h to 74h select the five operating modes.
// RULE12: 75h enables emission, 76h selects standby.
// RULE13: single byte 7Eh requests status, never inside a frame.
// RULE14: status reply is six bytes with 1 ms pauses between them.
// RULE15: status requests are answered in every mode.
// RULE16: status one bits 0-2 give mode, 101 under remote.
// RULE17: status one bit 3 remote, bit 4 laser on, bit 5 pull-up.
// RULE18: status one bits 6-7 give pulse frequency.
// RULE19: status two holds power-up lasing, ceiling and firmware version.
// RULE20: reset gives manual, pull-up, 5 kHz, no power-up lasing, 95%.
// RULE21: every accepted command is pushed to non-volatile storage.
// RULE22: status checksum is inverted sum of the four data bytes.
// RULE23: duty byte reports commanded duty; power byte from closed loop.
// RULE24: stray bytes outside a frame are ignored; replies end the frame.
// RULE25: unknown command codes are rejected with 3Fh.
`timescale 1ns/1ps
`default_nettype none
module laser_serial_command_parser
  import laser_cmd_pkg::*;
#(
  parameter int BIT_CYC_P = BIT_CYC,
  parameter int TMO_CYC_P = TMO_CYC,
  parameter int GAP_CYC_P = GAP_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic serial_rx,
  input wire logic remote_ctrl,
  input wire logic [7:0] power_byte,
  output logic serial_tx,
  output cfg_s settings,
  output logic nv_write,
  output cfg_s nv_data,
  output logic [7:0] status_reply_byte_one,
  output logic [7:0] status_reply_byte_two
);
  // ------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------
  logic rx_s1_q, rx_s2_q, rx_busy_q, rx_vld_q;
  logic [31:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q, rx_byte_q;
  wire rx_tick = rx_busy_q && rx_cnt_q == 32'h0;
  always_ff @(posedge clk_sys) begin
    rx_s1_q <= serial_rx;
    rx_s2_q <= rx_s1_q;
  end
  always_ff @(posedge clk_sys) begin // RULE1
    rx_vld_q <= 1'b0;
    if (rst) begin
      rx_busy_q <= 1'b0;
      rx_cnt_q <= 32'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_byte_q <= 8'h00;
    end else if (!rx_busy_q) begin
      rx_busy_q <= !rx_s2_q;
      rx_cnt_q <= 32'(BIT_CYC_P / 2);
      rx_bit_q <= 4'h0;
    end else if (rx_tick) begin
      rx_cnt_q <= 32'(BIT_CYC_P - 1);
      rx_bit_q <= rx_bit_q + 4'h1;
      if (rx_bit_q == 4'h0 && rx_s2_q) begin
        rx_busy_q <= 1'b0;
      end else if (rx_bit_q == LAST_BIT) begin
        rx_busy_q <= 1'b0;
        rx_vld_q <= rx_s2_q;
        rx_byte_q <= rx_sh_q;
      end else if (rx_bit_q != 4'h0) begin
        rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
      end
    end else begin
      rx_cnt_q <= rx_cnt_q - 32'h1;
    end
  end

  // ------------------------------------------------------------
  // frame parser
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD = 4'b0010,
    ST_DATA = 4'b0100,
    ST_SUM = 4'b1000
  } st_e;
  st_e st_q, st_d;
  logic [7:0] cmd_q, data_q;
  logic [31:0] tmo_q;
  cfg_s cfg_q, cfg_app;
  logic cmd_ok;
  wire in_frame = st_q != ST_IDLE;
  wire tmo_hit = in_frame && tmo_q == 32'(TMO_CYC_P - 1); // RULE9
  wire is_duty = cmd_q == C_DUTY;
  wire [7:0] dsum = cmd_q + data_q;
  wire [7:0] exp_sum = is_duty ? ~dsum : ~cmd_q; // RULE4 RULE6
  wire sum_in = rx_vld_q && st_q == ST_SUM;
  wire good = sum_in && rx_byte_q == exp_sum && cmd_ok && !tmo_hit;
  wire bad = (sum_in && !good) || tmo_hit; // RULE9 RULE25
  wire stat_req = rx_vld_q && st_q == ST_IDLE && rx_byte_q == B_STAT;
  // command decode onto the settings
  always_comb begin
    cfg_app = cfg_q;
    cmd_ok = 1'b1;
    case (cmd_q)
      C_F5: cfg_app.freq = F_5K; // RULE10
      C_F10: cfg_app.freq = F_10K;
      C_F20: cfg_app.freq = F_20K;
      C_PU: cfg_app.gate_pull_up = 1'b1;
      C_PD: cfg_app.gate_pull_up = 1'b0;
      C_C95: cfg_app.ceiling_95 = 1'b1;
      C_C99: cfg_app.ceiling_95 = 1'b0;
      C_PWR_ON: cfg_app.lase_at_power_up = 1'b1;
      C_PWR_OFF: cfg_app.lase_at_power_up = 1'b0;
      C_LASE: cfg_app.laser_on = 1'b1; // RULE12
      C_STBY: cfg_app.laser_on = 1'b0;
      C_DUTY: begin
        cfg_app.duty = data_q; // RULE7
        cmd_ok = data_q <= DUTY_MAX;
      end
      default: begin
        if (cmd_q >= C_MAN && cmd_q <= C_MAN + 8'(M_CL_ANALOG)) begin
          cfg_app.mode = 3'(cmd_q - C_MAN); // RULE11
        end else begin
          cmd_ok = 1'b0; // RULE25
        end
      end
    endcase
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: if (rx_vld_q && rx_byte_q == B_SOF) st_d = ST_CMD; // RULE3
      ST_CMD: if (rx_vld_q) st_d = rx_byte_q == C_DUTY ? ST_DATA : ST_SUM;
      ST_DATA: if (rx_vld_q) st_d = ST_SUM; // RULE5
      ST_SUM: if (rx_vld_q) st_d = ST_IDLE; // RULE2
      default: st_d = ST_IDLE;
    endcase
    if (tmo_hit) st_d = ST_IDLE; // RULE24
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= ST_IDLE;
      cmd_q <= 8'h00;
      data_q <= 8'h00;
      tmo_q <= 32'h0;
    end else begin
      st_q <= st_d;
      tmo_q <= in_frame ? tmo_q + 32'h1 : 32'h0;
      if (rx_vld_q && st_q == ST_CMD) cmd_q <= rx_byte_q;
      if (rx_vld_q && st_q == ST_DATA) data_q <= rx_byte_q;
    end
  end

  // settings and non-volatile push
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_q <= CFG_RST; // RULE20
      nv_write <= 1'b0;
      nv_data <= CFG_RST;
    end else begin
      nv_write <= good; // RULE21
      if (good) begin
        cfg_q <= cfg_app;
        nv_data <= cfg_app;
      end
    end
  end
  assign settings = cfg_q;
  // ------------------------------------------------------------
  // status bytes
  // ------------------------------------------------------------
  stat_one_s s1_d;
  stat_two_s s2_d;
  always_comb begin
    s1_d.mode = remote_ctrl ? M_REMOTE : cfg_q.mode; // RULE16
    s1_d.remote = remote_ctrl; // RULE17
    s1_d.laser_on = cfg_q.laser_on;
    s1_d.gate_pull_up = cfg_q.gate_pull_up;
    s1_d.freq = cfg_q.freq; // RULE18
    s2_d.lase_at_power_up = cfg_q.lase_at_power_up; // RULE19
    s2_d.ceiling_95 = cfg_q.ceiling_95;
    s2_d.rsvd = 2'h0;
    s2_d.fw = FW_VER;
  end
  always_ff @(posedge clk_sys) begin
    status_reply_byte_one <= s1_d;
    status_reply_byte_two <= s2_d;
  end

  // ------------------------------------------------------------
  // reply sequencer and transmitter
  // ------------------------------------------------------------
  logic [7:0] rep_q [REP_LEN];
  logic [2:0] rep_len_q, rep_idx_q;
  logic rep_act_q, tx_busy_q;
  logic [31:0] gap_q, tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [8:0] tx_sh_q;
  wire [7:0] st_sum = 8'(s1_d) + 8'(s2_d) + cfg_q.duty + power_byte;
  wire load = good || bad || stat_req;
  wire tx_start = rep_act_q && !tx_busy_q && gap_q == 32'h0 &&
    rep_idx_q < rep_len_q;
  wire tx_end = tx_busy_q && tx_cnt_q == 32'h0 && tx_bit_q == LAST_BIT;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rep_act_q <= 1'b0;
      rep_len_q <= 3'h0;
      rep_idx_q <= 3'h0;
      gap_q <= 32'h0;
      for (int i = 0; i < REP_LEN; i++) rep_q[i] <= 8'h00;
    end else if (load) begin
      rep_act_q <= 1'b1;
      rep_idx_q <= 3'h0;
      rep_len_q <= stat_req ? 3'(REP_LEN) : 3'h1; // RULE15
      rep_q[0] <= bad ? B_NAK : B_ACK; // RULE8 RULE9
      rep_q[1] <= s1_d; // RULE13
      rep_q[2] <= s2_d;
      rep_q[3] <= cfg_q.duty; // RULE23
      rep_q[4] <= power_byte;
      rep_q[5] <= ~st_sum; // RULE22
    end else begin
      if (tx_start) rep_idx_q <= rep_idx_q + 3'h1;
      if (tx_end && rep_idx_q < rep_len_q) begin
        gap_q <= 32'(GAP_CYC_P); // RULE14
      end else if (gap_q != 32'h0) begin
        gap_q <= gap_q - 32'h1;
      end
      if (!tx_busy_q && !tx_start && rep_idx_q == rep_len_q) begin
        rep_act_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_sys) begin // RULE1
    if (rst) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q <= 32'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h1FF;
      serial_tx <= 1'b1;
    end else if (tx_start) begin
      tx_busy_q <= 1'b1;
      tx_cnt_q <= 32'(BIT_CYC_P - 1);
      tx_bit_q <= 4'h0;
      tx_sh_q <= {1'b1, rep_q[rep_idx_q]};
      serial_tx <= 1'b0;
    end else if (tx_busy_q && tx_cnt_q == 32'h0) begin
      tx_cnt_q <= 32'(BIT_CYC_P - 1);
      tx_bit_q <= tx_bit_q + 4'h1;
      if (tx_bit_q == LAST_BIT) begin
        tx_busy_q <= 1'b0;
      end else begin
        serial_tx <= tx_sh_q[0];
        tx_sh_q <= {1'b1, tx_sh_q[8:1]};
      end
    end else if (tx_busy_q) begin
      tx_cnt_q <= tx_cnt_q - 32'h1;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  logic [31:0] quiet_q;
  always_ff @(posedge clk_sys) begin
    if (rst || tx_busy_q) quiet_q <= 32'h0;
    else if (quiet_q != 32'hFFFFFFFF) quiet_q <= quiet_q + 32'h1;
  end

  property p_sof_only;
    @(posedge clk_sys) disable iff (rst)
    (st_q == ST_IDLE && rx_vld_q && rx_byte_q != B_SOF) |=> st_q == ST_IDLE;
  endproperty
  a_sof_only: assert property (p_sof_only) else $error("frame opened"); // RULE3
  property p_ack;
    @(posedge clk_sys) disable iff (rst)
    good |=> rep_act_q && rep_q[0] == B_ACK && rep_len_q == 3'h1;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack"); // RULE8
  property p_nak;
    @(posedge clk_sys) disable iff (rst)
    (sum_in && rx_byte_q != exp_sum) |=> rep_q[0] == B_NAK;
  endproperty
  a_nak: assert property (p_nak) else $error("no nak"); // RULE9
  property p_tmo;
    @(posedge clk_sys) disable iff (rst)
    tmo_hit |=> st_q == ST_IDLE && rep_q[0] == B_NAK && tx_start;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout lost"); // RULE9
  property p_gap;
    @(posedge clk_sys) disable iff (rst)
    (tx_start && rep_idx_q != 3'h0) |-> quiet_q >= 32'(GAP_CYC_P);
  endproperty
  a_gap: assert property (p_gap) else $error("pause short"); // RULE14
  property p_stat;
    @(posedge clk_sys) disable iff (rst)
    stat_req |=> rep_len_q == 3'h6 && rep_q[0] == B_ACK && tx_start;
  endproperty
  a_stat: assert property (p_stat) else $error("status missed"); // RULE13
  property p_sum;
    @(posedge clk_sys) disable iff (rst)
    (rep_act_q && rep_len_q == 3'h6) |->
      8'(rep_q[1] + rep_q[2] + rep_q[3] + rep_q[4] + rep_q[5]) == 8'hFF;
  endproperty
  a_sum: assert property (p_sum) else $error("bad reply sum"); // RULE22
  property p_nv;
    @(posedge clk_sys) disable iff (rst)
    $changed(cfg_q) |-> nv_write && nv_data == cfg_q;
  endproperty
  a_nv: assert property (p_nv) else $error("no nv push"); // RULE21
  property p_start_bit;
    @(posedge clk_sys) disable iff (rst)
    tx_start |=> !serial_tx [*2];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start"); // RULE1
  property p_rst;
    @(posedge clk_sys) ($past(rst) && !rst) |-> cfg_q == CFG_RST;
  endproperty
  a_rst: assert property (p_rst) else $error("bad defaults"); // RULE20

  c_ack: cover property (@(posedge clk_sys) good);
  c_tmo: cover property (@(posedge clk_sys) tmo_hit);
  c_stat: cover property (@(posedge clk_sys) stat_req);
  c_duty: cover property (@(posedge clk_sys) good && is_duty);
endmodule
`default_nettype wire

// File: bench/host_uart.sv
// host serial port model: byte sender and reply receiver
`timescale 1ns/1ps
`default_nettype none
module host_uart #(
  parameter int BIT_CYC_P = 16
) (
  input wire logic clk_sys,
  input wire logic serial_tx,
  output logic serial_rx,
  output logic [7:0] rx_byte,
  output logic rx_vld
);
  logic [9:0] sh;
  initial begin
    serial_rx = 1'b1;
  end
  // ------------------------------------------------------------
  // sender: start, 8 data lsb first, stop, no parity
  // ------------------------------------------------------------
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys);
      serial_rx = f[i];
      repeat (BIT_CYC_P - 1) @(negedge clk_sys);
    end
  endtask
  // ------------------------------------------------------------
  // receiver: mid-bit sampling, bad framing gives unknown
  // ------------------------------------------------------------
  always begin
    @(negedge serial_tx);
    repeat (BIT_CYC_P / 2) @(negedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      sh[i] = serial_tx;
      if (i < 9) repeat (BIT_CYC_P) @(negedge clk_sys);
    end
    rx_byte = (!sh[0] && sh[9]) ? sh[8:1] : 8'hXX;
    rx_vld = 1'b1;
    @(negedge clk_sys);
    rx_vld = 1'b0;
  end
endmodule
`default_nettype wire

// File: bench/laser_serial_command_parser_tb.sv
// self-checking bench for the serial laser command interpreter
`timescale 1ns/1ps
`default_nettype none
module laser_serial_command_parser_tb;
  import laser_cmd_pkg::*;
  localparam int BC = 16;
  localparam int TC = 2000;
  localparam int GC = 40;
  logic clk_sys, rst, remote_ctrl;
  logic [7:0] power_byte;
  logic serial_rx, serial_tx, nv_write, rx_vld;
  logic [7:0] s1, s2, rx_byte, d;
  logic [7:0] nv_n = 8'h00;
  logic [7:0] n_acc = 8'h00;
  cfg_s settings, nv_data, cfg;
  logic [7:0] exp_q[$];
  int gap_q[$];
  int n_fail = 0;
  int checks_done = 0;
  int gap = 0;
  int waited;
  logic [7:0] codes[16] = '{8'h79, 8'h7B, 8'h7D, 8'h30, 8'h75, 8'h71,
    8'h72, 8'h73, 8'h74, 8'h78, 8'h77, 8'h7A, 8'h7C, 8'h31, 8'h76, 8'h70};
  always #4 clk_sys = ~clk_sys;
  laser_serial_command_parser #(.BIT_CYC_P(BC), .TMO_CYC_P(TC),
    .GAP_CYC_P(GC)) DUT (.clk_sys(clk_sys), .rst(rst),
    .serial_rx(serial_rx), .remote_ctrl(remote_ctrl),
    .power_byte(power_byte), .serial_tx(serial_tx),
    .settings(settings), .nv_write(nv_write), .nv_data(nv_data),
    .status_reply_byte_one(s1), .status_reply_byte_two(s2));
  host_uart #(.BIT_CYC_P(BC)) host (.clk_sys(clk_sys),
    .serial_tx(serial_tx), .serial_rx(serial_rx), .rx_byte(rx_byte),
    .rx_vld(rx_vld));
  // ------------------------------------------------------------
  // compares and closing
  // ------------------------------------------------------------
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_cfg(input cfg_s got, input cfg_s exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // expected settings and status
  // ------------------------------------------------------------
  function automatic cfg_s apply(input cfg_s c, input logic [7:0] k);
    case (k)
      8'h77, 8'h78, 8'h79: c.freq = 2'(k - 8'h77);
      8'h7A, 8'h7B: c.gate_pull_up = (k == 8'h7A);
      8'h7C, 8'h7D: c.ceiling_95 = (k == 8'h7C);
      8'h30, 8'h31: c.lase_at_power_up = (k == 8'h30);
      8'h75, 8'h76: c.laser_on = (k == 8'h75);
      default: c.mode = 3'(k - 8'h70);
    endcase
    return c;
  endfunction
  function automatic logic [7:0] st1(input cfg_s c);
    return {c.freq, c.gate_pull_up, c.laser_on, remote_ctrl,
      remote_ctrl ? 3'h5 : c.mode};
  endfunction
  function automatic logic [7:0] st2(input cfg_s c);
    return {FW_VER, 2'h0, c.ceiling_95, c.lase_at_power_up};
  endfunction
  // ------------------------------------------------------------
  // watcher of replies
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    gap <= gap + 1;
    if (nv_write === 1'b1) nv_n <= nv_n + 8'h01;
    if (rx_vld === 1'b1) begin
      gap <= 0;
      if (exp_q.size() == 0) begin
        check_byte(8'(exp_q.size()), 8'h01);
      end else begin
        check_byte(rx_byte, exp_q.pop_front());
        check_byte({7'h00, gap >= gap_q.pop_front()}, 8'h01);
      end
    end
  end
  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task automatic drain(input int lim);
    waited = 0;
    while (exp_q.size() != 0 && waited < lim) begin
      @(negedge clk_sys);
      waited++;
    end
    if (exp_q.size() != 0) begin
      check_byte(8'(exp_q.size()), 8'h00);
      complete_run();
    end else begin
      repeat (4) @(negedge clk_sys);
    end
  endtask
  task automatic check_state;
    check_cfg(settings, cfg);
    check_cfg(nv_data, cfg);
    check_byte(nv_n, n_acc);
    check_byte(s1, st1(cfg));
    check_byte(s2, st2(cfg));
  endtask
  task automatic frame(input logic [7:0] k, input logic [7:0] v,
      input logic [7:0] sum, input logic [7:0] rsp);
    exp_q.push_back(rsp);
    gap_q.push_back(0);
    host.send_byte(8'h5B);
    host.send_byte(k);
    if (k == 8'h7F) host.send_byte(v);
    host.send_byte(sum);
    drain(2000);
    if (rsp == 8'hAA) begin
      n_acc++;
      cfg = (k == 8'h7F) ? {cfg[16:8], v} : apply(cfg, k);
    end
    check_state();
  endtask
  task automatic status(input logic r);
    logic [7:0] a, b, p;
    logic [7:0] r6[6];
    remote_ctrl = r;
    power_byte = 8'($urandom);
    repeat (2) @(negedge clk_sys);
    a = st1(cfg);
    b = st2(cfg);
    p = power_byte;
    r6 = '{8'hAA, a, b, cfg.duty, p, ~(a + b + cfg.duty + p)};
    foreach (r6[i]) begin
      exp_q.push_back(r6[i]);
      gap_q.push_back(i == 0 ? 0 : 10 * BC + GC);
    end
    host.send_byte(8'h7E);
    drain(3000);
    check_state();
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    remote_ctrl = 1'b0;
    power_byte = 8'h00;
    void'($urandom(45));
    cfg = CFG_RST;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    check_byte(s1, 8'h20);
    check_state();
    $display("test reset done");
    foreach (codes[i]) begin
      if (i == 8) status(1'b0);
      frame(codes[i], 8'h00, ~codes[i], 8'hAA);
    end
    $display("test command codes done");
    frame(8'h7F, 8'hC6, 8'hBA, 8'hAA);
    frame(8'h7F, 8'hC7, 8'hB9, 8'h3F);
    d = 8'($urandom % 199);
    frame(8'h7F, d, ~(8'h7F + d), 8'hAA);
    status(1'b1);
    $display("test duty and status done");
    frame(8'h75, 8'h00, 8'h00, 8'h3F);
    frame(8'h50, 8'h00, 8'hAF, 8'h3F);
    exp_q.push_back(8'h3F);
    gap_q.push_back(0);
    host.send_byte(8'h5B);
    drain(3000);
    check_byte({7'h00, waited >= TC}, 8'h01);
    check_state();
    $display("test rejects done");
    host.send_byte(8'h00);
    host.send_byte(8'hC3);
    repeat (200) @(negedge clk_sys);
    frame(8'h79, 8'h00, 8'h86, 8'hAA);
    $display("test stray bytes done");
    complete_run();
  end
endmodule
`default_nettype wire
